// File: pkg/swrg_pkg.sv
// Package for the warm-reset refresh guard of the SDRAM controller.
// Assumes a single 20 MHz controller clock and no software register bus.
package swrg_pkg;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int unsigned SWRG_RATE_W          = 16;
  localparam logic [15:0] SWRG_RATE_RST        = 16'h0000;
  localparam int unsigned SWRG_SPARE_W         = 8;
  localparam int unsigned SWRG_EXTEND_BIT      = 6;
  localparam int unsigned SWRG_HOLD_W          = 16;
  localparam logic [15:0] SWRG_HOLD_CYC_DFLT   = 16'h0040;
  localparam int unsigned SWRG_SYNC_STAGES     = 3;

  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [2:0] {
    SWRG_ACTIVE,
    SWRG_ENTER_SR,
    SWRG_HOLD_SR,
    SWRG_EXTEND_SR,
    SWRG_EXIT_SR
  } swrg_state_t;

endpackage

// File: src/swrg_sync.sv
// Three-stage synchroniser for one level from outside the clock domain.
// The output changes once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module swrg_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic [2:0] stg;
    logic       out;
  } swrg_sync_t;

  swrg_sync_t s_q;
  swrg_sync_t s_d;

  // Shift the level in; only the agreeing later stages update the output.
  always_comb begin
    s_d     = s_q;
    s_d.stg = {s_q.stg[1:0], din};
    if (s_q.stg[1] == s_q.stg[2]) begin
      s_d.out = s_q.stg[2];
    end
  end

  // Register the whole state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;

endmodule
`default_nettype wire

// File: src/swrg_guard.sv
// Warm-reset refresh guard of an SDRAM controller: refresh timer,
// self-refresh entry on warm reset, and its default or extended exit.
// Assumes warm reset, power-on reset and PLL lock come from pins outside
// this clock domain; the memory command path sits downstream.
// Only the PLL status pin, a power-on reset or RST releases an extended self-refresh.
//
// Functional notes
// - The refresh interval is a 16-bit count of controller clock cycles.
// - Under warm reset the clock drops to bypass rate so refresh is late.
// - Warm reset sends the controller idle and the SDRAM to self-refresh.
// - By default the SDRAM leaves self-refresh after the warm hold time.
// - With spare-control bit 6 set the self-refresh is prolonged.
`timescale 1ns/1ns
`default_nettype none
module swrg_guard #(
  parameter int unsigned RATE_W = swrg_pkg::SWRG_RATE_W,
  parameter int unsigned HOLD_W = swrg_pkg::SWRG_HOLD_W
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Reset and clock management pins
  input  wire logic              WARM_RESET,
  input  wire logic              POWER_ON_RESET_N,
  input  wire logic              PLL_FUNCTIONAL,
  // Static configuration
  input  wire logic [RATE_W-1:0] SDRAM_REFRESH_SETUP,
  input  wire logic [7:0]        CORE_SPARE_CONTROL,
  input  wire logic [HOLD_W-1:0] WARM_RESET_HOLD_TIME,
  // Access request from the controller core
  input  wire logic              ACCESS_REQ,
  output logic                   ACCESS_GRANT,
  // SDRAM command strobes
  output logic                   SDRAM_REFRESH,
  output logic                   SDRAM_SR_ENTER,
  output logic                   SDRAM_SR_EXIT,
  // Status
  output logic                   CTRL_IDLE,
  output logic                   SELF_REFRESH
);

  // ****************************************
  // Synchronised pins
  // ****************************************
  // Each pin reaches the state machine four edges after it settles, so
  // the hold timer below counts from that delayed view of the pin.
  logic warm_s;
  logic por_n_s;
  logic pll_s;

  // Warm reset request from the reset manager.
  swrg_sync u_warm (
    .clk  (CLOCK),
    .rst  (RST),
    .din  (WARM_RESET),
    .dout (warm_s)
  );

  // Power-on reset, low while asserted.
  swrg_sync u_por (
    .clk  (CLOCK),
    .rst  (RST),
    .din  (POWER_ON_RESET_N),
    .dout (por_n_s)
  );

  // PLL back at its functional rate.
  swrg_sync u_pll (
    .clk  (CLOCK),
    .rst  (RST),
    .din  (PLL_FUNCTIONAL),
    .dout (pll_s)
  );

  // ****************************************
  // State
  // ****************************************
  // All state lives in one packed word so reset and update stay in step.
  typedef struct packed {
    swrg_pkg::swrg_state_t st;
    logic [RATE_W-1:0]     ref_cnt;
    logic [HOLD_W-1:0]     hold_cnt;
    logic                  refresh;
    logic                  sr_enter;
    logic                  sr_exit;
    logic                  idle;
    logic                  in_sr;
  } swrg_guard_t;

  swrg_guard_t g_q;
  swrg_guard_t g_d;
  logic        extend;

  // ****************************************
  // Helpers
  // ****************************************
  // Count reaching zero; shared by both timers.
  function automatic logic at_zero(input logic [15:0] v);
    at_zero = (v == 16'h0000);
  endfunction

  // The extend bit is a static strap; a change while held takes effect
  // only at the next hold expiry.
  // extend bit decode
  assign extend = CORE_SPARE_CONTROL[swrg_pkg::SWRG_EXTEND_BIT];

  // ****************************************
  // Next-state logic
  // ****************************************
  // A power-on reset restarts everything, so a warm reset promoted to
  // cold by the system also lands here cleanly. Pulses default to zero
  // each cycle so every SDRAM command lasts one clock; levels hold until
  // the state machine moves them.
  always_comb begin
    g_d          = g_q;
    g_d.refresh  = 1'b0;
    g_d.sr_enter = 1'b0;
    g_d.sr_exit  = 1'b0;
    if (!por_n_s) begin
      // A zero count makes refresh resume at once after the cold start.
      g_d.st       = swrg_pkg::SWRG_ACTIVE;
      g_d.ref_cnt  = RATE_W'(swrg_pkg::SWRG_RATE_RST);
      g_d.hold_cnt = '0;
      g_d.idle     = 1'b0;
      g_d.in_sr    = 1'b0;
    end else begin
      case (g_q.st)
        swrg_pkg::SWRG_ACTIVE: begin
          g_d.idle = 1'b0;
          if (warm_s) begin
            g_d.st       = swrg_pkg::SWRG_ENTER_SR;
            g_d.idle     = 1'b1;
          end else if (at_zero(16'(g_q.ref_cnt))) begin
            // refresh on interval expiry
            // A zero interval turns refresh off instead of pulsing always.
            g_d.refresh = (SDRAM_REFRESH_SETUP != '0);
            g_d.ref_cnt = SDRAM_REFRESH_SETUP;
          end else begin
            g_d.ref_cnt = g_q.ref_cnt - 1'b1;
          end
        end
        swrg_pkg::SWRG_ENTER_SR: begin
          // Loading the hold here keeps a short warm pulse from skipping it.
          g_d.sr_enter = 1'b1;
          g_d.in_sr    = 1'b1;
          g_d.hold_cnt = WARM_RESET_HOLD_TIME;
          g_d.st       = swrg_pkg::SWRG_HOLD_SR;
        end
        swrg_pkg::SWRG_HOLD_SR: begin
          // refresh timer frozen at bypass rate
          // A warm reset that returns before the hold ends restarts it, so
          // the hold always runs in full after the last release.
          if (warm_s) begin
            g_d.hold_cnt = WARM_RESET_HOLD_TIME;
          end else if (!at_zero(16'(g_q.hold_cnt))) begin
            g_d.hold_cnt = g_q.hold_cnt - 1'b1;
          end else if (extend) begin
            g_d.st = swrg_pkg::SWRG_EXTEND_SR;
          end else begin
            g_d.st = swrg_pkg::SWRG_EXIT_SR;
          end
        end
        swrg_pkg::SWRG_EXTEND_SR: begin
          // PLL restored before exit
          // A new warm reset here restarts the hold instead of exiting.
          if (warm_s) begin
            g_d.st       = swrg_pkg::SWRG_HOLD_SR;
            g_d.hold_cnt = WARM_RESET_HOLD_TIME;
          end else if (pll_s) begin
            g_d.st = swrg_pkg::SWRG_EXIT_SR;
          end
        end
        swrg_pkg::SWRG_EXIT_SR: begin
          // The refresh timer restarts in full once the clock is back.
          g_d.sr_exit = 1'b1;
          g_d.in_sr   = 1'b0;
          g_d.idle    = 1'b0;
          g_d.ref_cnt = SDRAM_REFRESH_SETUP;
          g_d.st      = swrg_pkg::SWRG_ACTIVE;
        end
        default: begin
          // An unused code falls back to normal operation.
          g_d.st = swrg_pkg::SWRG_ACTIVE;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Register the whole state.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      g_q <= '0;
    end else begin
      g_q <= g_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // The grant is combinational so a request is served in its own cycle;
  // the price is a path from the request pin to the grant pin.
  // no access while idle
  assign ACCESS_GRANT   = ACCESS_REQ && !g_q.idle && !g_q.in_sr;
  assign SDRAM_REFRESH  = g_q.refresh;
  assign SDRAM_SR_ENTER = g_q.sr_enter;
  assign SDRAM_SR_EXIT  = g_q.sr_exit;
  assign CTRL_IDLE      = g_q.idle;
  assign SELF_REFRESH   = g_q.in_sr;

endmodule
`default_nettype wire

// File: bench/swrg_guard_sva.sv
// Checker of the warm-reset refresh guard, bound to its top module.
// Assumes one clock domain; checks pause while either reset is asserted.
`timescale 1ns/1ns
`default_nettype none
module swrg_guard_chk #(
  parameter int unsigned RATE_W = 16,
  parameter int unsigned HOLD_W = 16
) (
  // Clock, reset and pins
  input wire logic              CLOCK,
  input wire logic              RST,
  input wire logic              WARM_RESET,
  input wire logic              POWER_ON_RESET_N,
  input wire logic              PLL_FUNCTIONAL,
  // Configuration
  input wire logic [RATE_W-1:0] SDRAM_REFRESH_SETUP,
  input wire logic [7:0]        CORE_SPARE_CONTROL,
  input wire logic [HOLD_W-1:0] WARM_RESET_HOLD_TIME,
  // Outputs watched
  input wire logic              ACCESS_GRANT,
  input wire logic              SDRAM_REFRESH,
  input wire logic              SDRAM_SR_ENTER,
  input wire logic              SDRAM_SR_EXIT,
  input wire logic              CTRL_IDLE,
  input wire logic              SELF_REFRESH
);
  logic [16:0]     low_q;
  logic [RATE_W:0] gap_q;
  logic            vld_q;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST || !POWER_ON_RESET_N);
  // Cycles since warm pin low and since last refresh; gap valid in active.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      low_q <= '0;
      gap_q <= '0;
      vld_q <= 1'b0;
    end else begin
      low_q <= WARM_RESET ? '0 : (&low_q ? low_q : low_q + 1'b1);
      gap_q <= SDRAM_REFRESH ? '0 : gap_q + 1'b1;
      vld_q <= POWER_ON_RESET_N &
               (SDRAM_REFRESH | (vld_q & ~CTRL_IDLE & ~SELF_REFRESH));
    end
  end
  a_refresh_gap: assert property (SDRAM_REFRESH && vld_q |->
    gap_q == SDRAM_REFRESH_SETUP) else $error("refresh interval wrong");
  a_refresh_due: assert property (vld_q && !CTRL_IDLE |->
    gap_q <= SDRAM_REFRESH_SETUP) else $error("refresh overdue");
  a_warm_idle: assert property ($rose(WARM_RESET) |->
    ##[2:6] CTRL_IDLE) else $error("warm reset not taken");
  a_idle_enter: assert property ($rose(CTRL_IDLE) |=>
    SDRAM_SR_ENTER && SELF_REFRESH) else $error("no self-refresh entry");
  a_exit_clean: assert property ($fell(SELF_REFRESH) |->
    SDRAM_SR_EXIT && !CTRL_IDLE) else $error("bad self-refresh exit");
  a_exit_hold: assert property (SDRAM_SR_EXIT |->
    low_q > WARM_RESET_HOLD_TIME) else $error("exit before hold time");
  a_default_exit: assert property (!CORE_SPARE_CONTROL[6] &&
    low_q == WARM_RESET_HOLD_TIME + 12 |-> !SELF_REFRESH)
    else $error("default exit missing");
  a_extend_pll: assert property (SDRAM_SR_EXIT && CORE_SPARE_CONTROL[6]
    |-> $past(PLL_FUNCTIONAL, 3)) else $error("extended exit early");
  a_sr_quiet: assert property (SELF_REFRESH && $past(SELF_REFRESH) |->
    !SDRAM_REFRESH) else $error("refresh in self-refresh");
  a_grant_gate: assert property (CTRL_IDLE || SELF_REFRESH |->
    !ACCESS_GRANT) else $error("access while idle");
endmodule
bind swrg_guard swrg_guard_chk #(.RATE_W(RATE_W), .HOLD_W(HOLD_W)) u_chk (
  .CLOCK, .RST, .WARM_RESET, .POWER_ON_RESET_N, .PLL_FUNCTIONAL,
  .SDRAM_REFRESH_SETUP, .CORE_SPARE_CONTROL, .WARM_RESET_HOLD_TIME,
  .ACCESS_GRANT, .SDRAM_REFRESH, .SDRAM_SR_ENTER, .SDRAM_SR_EXIT,
  .CTRL_IDLE, .SELF_REFRESH);
`default_nettype wire

// File: bench/swrg_sdram_model.sv
// Behavioural SDRAM: tracks self-refresh and counts misplaced commands.
// Assumes command strobes are one-cycle pulses on the controller clock.
`timescale 1ns/1ns
`default_nettype none
module swrg_sdram_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Commands
  input  wire logic refresh,
  input  wire logic sr_enter,
  input  wire logic sr_exit,
  // State seen
  output logic      in_sr,
  output var int    n_bad
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_sr <= 1'b0;
      n_bad <= 0;
    end else begin
      in_sr <= sr_enter | (in_sr & ~sr_exit);
      if ((refresh | sr_enter) & in_sr | sr_exit & ~in_sr) n_bad <= n_bad + 1;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_swrg_guard.sv
// Testbench of the refresh guard: refresh cadence, warm entry and exits.
// Assumes the checker is bound; power-on reset pulses once, with warm.
`timescale 1ns/1ns
`default_nettype none
module tb_swrg_guard;
  logic CLOCK, RST, WARM_RESET, POWER_ON_RESET_N, PLL_FUNCTIONAL, ACCESS_REQ;
  logic [15:0] SDRAM_REFRESH_SETUP, WARM_RESET_HOLD_TIME;
  logic [7:0]  CORE_SPARE_CONTROL;
  logic ACCESS_GRANT, SDRAM_REFRESH, SDRAM_SR_ENTER, SDRAM_SR_EXIT;
  logic CTRL_IDLE, SELF_REFRESH, mdl_sr;
  int   n_errors, num_checks, mdl_bad, n, k;
  swrg_guard u_swrg_guard (.CLOCK, .RST, .WARM_RESET, .POWER_ON_RESET_N,
    .PLL_FUNCTIONAL, .SDRAM_REFRESH_SETUP, .CORE_SPARE_CONTROL,
    .WARM_RESET_HOLD_TIME, .ACCESS_REQ, .ACCESS_GRANT, .SDRAM_REFRESH,
    .SDRAM_SR_ENTER, .SDRAM_SR_EXIT, .CTRL_IDLE, .SELF_REFRESH);
  swrg_sdram_model u_swrg_sdram_model (.clk(CLOCK), .rst(RST),
    .refresh(SDRAM_REFRESH), .sr_enter(SDRAM_SR_ENTER),
    .sr_exit(SDRAM_SR_EXIT), .in_sr(mdl_sr), .n_bad(mdl_bad));
  // A 50 ns clock.
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait so a stuck self-refresh cannot hang the run.
  task automatic wait_sr(input logic lvl);
    n = 0;
    while (SELF_REFRESH !== lvl) begin
      @(negedge CLOCK);
      n++;
      if (n > 400) begin
        check("sr_wait", 0, 1);
        print_verdict();
      end
    end
  endtask
  // Shortest default stay: three sync stages plus hold plus one.
  function automatic int min_sr(input int hold);
    return hold + 4;
  endfunction
  // Random core traffic across exactly four refresh intervals; one idle
  // edge at the end keeps the request from being driven twice at once.
  task automatic traffic;
    k = 0;
    repeat (8) @(negedge CLOCK);
    repeat (4 * (SDRAM_REFRESH_SETUP + 1)) begin
      @(negedge CLOCK);
      check("grant", ACCESS_GRANT, ACCESS_REQ);
      k += SDRAM_REFRESH;
      ACCESS_REQ = 1'($urandom);
    end
    check("refresh_count", k, 4);
    @(negedge CLOCK);
  endtask
  initial begin
    void'($urandom(32'hE942099E));
    {RST, WARM_RESET, POWER_ON_RESET_N, PLL_FUNCTIONAL} = 4'hB;
    ACCESS_REQ = 1'b0;
    CORE_SPARE_CONTROL = 8'($urandom) & 8'hBF;
    SDRAM_REFRESH_SETUP = 16'(5 + $urandom % 30);
    WARM_RESET_HOLD_TIME = 16'(8 + $urandom % 24);
    repeat (4) @(negedge CLOCK);
    RST = 1'b0;
    traffic();
    // Default exit first, then extended exit released by the PLL pin.
    for (int e = 0; e < 2; e++) begin
      CORE_SPARE_CONTROL[6] = e[0];
      PLL_FUNCTIONAL = ~e[0];
      ACCESS_REQ = 1'b1;
      WARM_RESET = 1'b1;
      repeat (10) @(negedge CLOCK);
      check("idle", {CTRL_IDLE, SELF_REFRESH, ACCESS_GRANT}, 3'h6);
      WARM_RESET = 1'b0;
      repeat (3) @(negedge CLOCK);
      WARM_RESET = 1'b1;
      repeat (6) @(negedge CLOCK);
      WARM_RESET = 1'b0;
      if (e == 1) begin
        repeat (WARM_RESET_HOLD_TIME + 40) @(negedge CLOCK);
        check("extend", SELF_REFRESH, 1);
        PLL_FUNCTIONAL = 1'b1;
      end
      wait_sr(1'b0);
      if (e == 0) check("hold", n >= min_sr(WARM_RESET_HOLD_TIME), 1);
      @(negedge CLOCK);
      check("back", {mdl_sr, CTRL_IDLE, ACCESS_GRANT}, 3'h1);
    end
    WARM_RESET = 1'b1;
    POWER_ON_RESET_N = 1'b0;
    repeat (5) @(negedge CLOCK);
    k = 0;
    repeat (8) begin
      @(negedge CLOCK);
      k += SDRAM_REFRESH | SDRAM_SR_ENTER | CTRL_IDLE | SELF_REFRESH;
    end
    check("cold_quiet", k, 0);
    WARM_RESET = 1'b0;
    POWER_ON_RESET_N = 1'b1;
    traffic();
    check("model_bad", mdl_bad, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
